// ===== bench/boost_regulator_control_registers_tb.sv
`timescale 1ns/100ps
module boost_regulator_control_registers_tb;
	logic clock_i, sys_rst_i, scl, sda, sda_o, sda_oe_o, enable_i, byp_n, lvl;
	logic pg_i, pg_o, pg_oe_o, pg_drv, ok;
	logic [7:0] rd;
	brc_pkg::stat_t status_i;
	brc_pkg::ctrl_t ctrl_o;
	int err_count = 0;
	int samples_checked = 0;
	logic [7:0] rst_tab [4] = '{8'h09, 8'h0f, 8'h11, 8'h1d};

	// The power-good pin is open drain with a pull-up; pg_drv high means released.
	assign pg_i = pg_drv & ~pg_oe_o;

	boost_regulator_control_registers u_boost_regulator_control_registers (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_o(sda_oe_o), .enable_i(enable_i),
		.bypass_request_n_i(byp_n), .output_level_select_i(lvl), .pg_i(pg_i),
		.pg_o(pg_o), .pg_oe_o(pg_oe_o), .status_i(status_i), .ctrl_o(ctrl_o));

	i2c_host_model u_i2c_host_model (.clock_i(clock_i), .sda_oe_i(sda_oe_o), .scl_o(scl),
		.sda_o(sda));

	// Free-running system clock.
	initial begin
		clock_i = 1'b0;
		forever #2 clock_i = ~clock_i;
	end

	task automatic check_val(input string what, input logic [16:0] exp, input logic [16:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Pins pass three sync flops and a filter, so eight clocks covers the lag.
	task automatic settle();
		repeat (8) @(negedge clock_i);
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
		u_i2c_host_model.write_reg(brc_pkg::DEV_ADDR, ptr, val, ok);
		check_val("write ack", 17'h1, {16'h0, ok});
	endtask

	task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
		u_i2c_host_model.read_reg(ptr, rd, ok);
		check_val("read ack", 17'h1, {16'h0, ok});
		check_val("read data", {9'h0, exp}, {9'h0, rd});
	endtask

	task automatic mode_chk(input logic [7:0] cfg, input logic l, input logic [2:0] exp);
		wr(brc_pkg::REG_CFG, cfg);
		lvl = l;
		settle();
		check_val("mode bits", {14'h0, exp}, {14'h0, ctrl_o.id_detect_enable,
			ctrl_o.spread_spectrum_enable, ctrl_o.forced_pwm});
	endtask

	// A hung run is cut short and reported as a failure.
	initial begin
		repeat (90000) @(posedge clock_i);
		err_count++;
		complete_run();
	end

	// Main sequence; the switching mode field is never written with 00.
	initial begin
		sys_rst_i = 1'b1;
		enable_i = 1'b0;
		byp_n = 1'b1;
		lvl = 1'b0;
		pg_drv = 1'b1;
		status_i = 8'h00;
		repeat (16) @(negedge clock_i);
		sys_rst_i = 1'b0;
		enable_i = 1'b1;
		settle();
		foreach (rst_tab[i]) rd_chk(8'(i + 1), rst_tab[i]);
		check_val("target", 17'h0f, {12'h0, ctrl_o.target_code});
		check_val("limit code", 17'hd, {13'h0, ctrl_o.current_limit_code});
		check_val("run mode", 17'h1, {15'h0, ctrl_o.run_mode});
		check_val("pg pull", 17'h1, {16'h0, pg_oe_o});
		byp_n = 1'b0;
		lvl = 1'b1;
		settle();
		check_val("run mode", 17'h2, {15'h0, ctrl_o.run_mode});
		check_val("target", 17'h11, {12'h0, ctrl_o.target_code});
		// The bypass request stays asserted, so only the override can change the mode.
		for (int ov = 1; ov < 4; ov++) begin
			wr(brc_pkg::REG_CFG, {1'b0, 2'(ov), 5'h09});
			settle();
			check_val("override", 17'(ov), {15'h0, ctrl_o.run_mode});
		end
		rd_chk(brc_pkg::REG_CFG, 8'h69);
		mode_chk(8'h8d, 1'b0, 3'b110);
		mode_chk(8'h0a, 1'b0, 3'b001);
		mode_chk(8'h0b, 1'b0, 3'b000);
		mode_chk(8'h0b, 1'b1, 3'b001);
		lvl = 1'b0;
		byp_n = 1'b1;
		status_i = 8'h01;
		settle();
		check_val("pg pull", 17'h0, {16'h0, pg_oe_o});
		check_val("pin levels", 17'h0, {15'h0, pg_o, sda_o});
		// The pin is low before its role turns to input, where a low level forces shutdown.
		pg_drv = 1'b0;
		wr(brc_pkg::REG_CFG, 8'h01);
		settle();
		check_val("run mode", 17'h3, {15'h0, ctrl_o.run_mode});
		check_val("pin role", 17'h0, {16'h0, ctrl_o.power_good_pin_role});
		wr(brc_pkg::REG_CFG, 8'h09);
		pg_drv = 1'b1;
		settle();
		check_val("run mode", 17'h1, {15'h0, ctrl_o.run_mode});
		wr(brc_pkg::REG_FLOOR, 8'hff);
		rd_chk(brc_pkg::REG_FLOOR, 8'hff);
		check_val("target", 17'h1f, {12'h0, ctrl_o.target_code});
		wr(brc_pkg::REG_LIMIT, 8'h28);
		check_val("limit", 17'h22, {11'h0, ctrl_o.current_limit_code,
			ctrl_o.current_limit_disable, ctrl_o.soft_start_limit});
		// One-cycle events must be caught and held until read.
		status_i = 8'h8f;
		@(negedge clock_i);
		// Live level bits show through while the latched ones clear on readout.
		status_i = 8'h71;
		rd_chk(brc_pkg::REG_STAT, 8'hff);
		rd_chk(brc_pkg::REG_STAT, 8'h71);
		wr(brc_pkg::REG_STAT, 8'hff);
		rd_chk(brc_pkg::REG_STAT, 8'h71);
		rd_chk(8'h07, 8'h00);
		u_i2c_host_model.write_reg(7'h74, brc_pkg::REG_FLOOR, 8'h00, ok);
		check_val("foreign ack", 17'h0, {16'h0, ok});
		rd_chk(brc_pkg::REG_FLOOR, 8'hff);
		enable_i = 1'b0;
		settle();
		check_val("run mode", 17'h0, {15'h0, ctrl_o.run_mode});
		enable_i = 1'b1;
		settle();
		rd_chk(brc_pkg::REG_FLOOR, 8'h0f);
		rd_chk(brc_pkg::REG_LIMIT, 8'h1d);
		complete_run();
	end
endmodule // boost_regulator_control_registers_tb

// ===== bench/i2c_host_model.sv
`timescale 1ns/100ps
// Host controller on the serial link; it only pulls the data line low.
module i2c_host_model (
	input wire logic clock_i,
	input wire logic sda_oe_i,
	output logic scl_o,
	output logic sda_o
);
	logic pull_low;

	// A pull-up resolves the wire, so a released line reads high.
	assign sda_o = ~(pull_low | sda_oe_i);

	// The clock stands high between frames.
	initial begin
		scl_o = 1'b1;
		pull_low = 1'b0;
	end

	// Eight clocks a phase stays clear of the four that the filter needs.
	task automatic half();
		repeat (8) @(negedge clock_i);
	endtask

	// Data moves one clock after the clock falls, so it never looks like a start or stop.
	task automatic start();
		@(negedge clock_i);
		pull_low = 1'b0;
		half();
		scl_o = 1'b1;
		half();
		pull_low = 1'b1;
		half();
		scl_o = 1'b0;
	endtask

	task automatic stop();
		@(negedge clock_i);
		pull_low = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		pull_low = 1'b0;
		half();
	endtask

	// The line is sampled at the end of the high phase, where the device has settled.
	task automatic bit_io(input logic b, output logic seen);
		@(negedge clock_i);
		pull_low = ~b;
		half();
		scl_o = 1'b1;
		half();
		seen = sda_o;
		scl_o = 1'b0;
	endtask

	// The ninth bit is released; on a read it is the final refusal.
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], s);
			rx[i] = s;
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] val, output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2;
		start();
		byte_io({dev, 1'b0}, rx, a0);
		byte_io(ptr, rx, a1);
		byte_io(val, rx, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [7:0] ptr, output logic [7:0] val, output logic ok);
		logic a0, a1, a2, na;
		start();
		byte_io({brc_pkg::DEV_ADDR, 1'b0}, val, a0);
		byte_io(ptr, val, a1);
		start();
		byte_io({brc_pkg::DEV_ADDR, 1'b1}, val, a2);
		byte_io(8'hff, val, na);
		stop();
		ok = a0 & a1 & a2;
	endtask
endmodule // i2c_host_model

// ===== common/brc_pkg.sv
// What this block does
// R1: Override 00 makes operation follow the enable and bypass request pins only.
// R2: Override 01 with enable high selects automatic boost/bypass, bypass pin ignored.
// R3: Override 10 with enable high forces pass-through, bypass pin ignored.
// R4: Override 11 with enable high forces shutdown with minimum output.
// R5: Configuration bit 7 enables identification detection when 1; resets to 0.
// R6: Configuration bit 3 (reset 1) selects power-good output, else shutdown input.
// R7: Configuration bit 2 enables spread spectrum in PWM; resets to 0.
// R8: Switching mode 01 is PFM with auto PWM, 10 forced PWM; 00 forbidden.
// R9: Switching mode 11 gives auto PWM with level select low, forced PWM high.
// R10: Floor register holds a 5-bit code in bits 4:0, 2.85V plus 50mV steps.
// R11: Floor code resets to 01111, a 3.6V target.
// R12: Ceiling register uses the same code, reset 10001, a 3.7V target.
// R13: Current limit code 1000..1111 maps 1500mA..5000mA; resets to 1101.
// R14: Thermal, bypass limit, boost limit and fault flags latch, cleared by reading.
// R15: The device answers at 7-bit serial address 1110101 only.
// R16: Status writes are ignored; other registers read back what was written.
// R17: All fields take reset values at power-up and while enable is low.
package brc_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h75;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_FLOOR = 8'h02;
	localparam logic [7:0] REG_CEIL = 8'h03;
	localparam logic [7:0] REG_LIMIT = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h05;
	localparam logic [7:0] CFG_RST = 8'h09;
	localparam logic [7:0] FLOOR_RST = 8'h0f;
	localparam logic [7:0] CEIL_RST = 8'h11;
	localparam logic [7:0] LIMIT_RST = 8'h1d;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] STICKY_MASK = 8'h8e;
	localparam int CFG_ID_BIT = 7;
	localparam int CFG_OVR_MSB = 6;
	localparam int CFG_OVR_LSB = 5;
	localparam int CFG_PG_BIT = 3;
	localparam int CFG_SS_BIT = 2;
	localparam int CFG_PM_MSB = 1;
	localparam int CFG_PM_LSB = 0;
	localparam int CODE_MSB = 4;
	localparam int LIM_OFF_BIT = 5;
	localparam int LIM_SS_BIT = 4;
	localparam int LIM_CODE_MSB = 3;
	localparam int ST_THERM = 7;
	localparam int ST_HOT = 6;
	localparam int ST_PULSE = 5;
	localparam int ST_OP_MODE = 4;
	localparam int ST_BYP_LIM = 3;
	localparam int ST_BST_LIM = 2;
	localparam int ST_FAULT = 1;
	localparam int ST_POWER_GOOD = 0;
	localparam logic [1:0] OVR_HW = 2'h0;
	localparam logic [1:0] OVR_AUTO = 2'h1;
	localparam logic [1:0] OVR_BYPASS = 2'h2;
	localparam logic [1:0] OVR_SHUT = 2'h3;
	localparam logic [1:0] PM_FORCED = 2'h2;
	localparam logic [1:0] PM_BY_PIN = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int NUM_PINS = 6;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_EN = 2;
	localparam int PIN_BYP_N = 3;
	localparam int PIN_LVL = 4;
	localparam int PIN_PG = 5;
	localparam logic [5:0] PIN_RST = 6'h2b;

	typedef enum logic [1:0] {RUN_OFF, RUN_AUTO, RUN_BYPASS, RUN_SHUTDOWN} run_mode_t;

	typedef struct packed {
		run_mode_t run_mode;
		logic forced_pwm;
		logic spread_spectrum_enable;
		logic id_detect_enable;
		logic power_good_pin_role;
		logic [4:0] target_code;
		logic [3:0] current_limit_code;
		logic current_limit_disable;
		logic soft_start_limit;
	} ctrl_t;

	typedef struct packed {
		logic thermal_shutdown_event;
		logic hot_die_flag;
		logic pulse_mode_flag;
		logic operation_mode_flag;
		logic bypass_current_limit_event;
		logic boost_current_limit_event;
		logic fault_event;
		logic power_good_flag;
	} stat_t;
endpackage

// ===== rtl/boost_regulator_control_registers.sv
`timescale 1ns/100ps
module boost_regulator_control_registers (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic enable_i,
	input wire logic bypass_request_n_i,
	input wire logic output_level_select_i,
	input wire logic pg_i,
	output logic pg_o,
	output logic pg_oe_o,
	input wire brc_pkg::stat_t status_i,
	output brc_pkg::ctrl_t ctrl_o
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR, ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
	} bus_state_t;

	logic [5:0] raw, s1_q, s2_q, s3_q, filt_q, filt_d, prev_q;
	logic scl_f, sda_f, en_f, byp_n_f, lvl_f, pg_f;
	logic scl_rise, scl_fall, start_det, stop_det;
	bus_state_t state_q, state_d;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_data;
	logic rw_q, rw_d, oe_q, oe_d, wr_en, load, rd_stat;
	logic [7:0] cfg_q, cfg_d, floor_q, floor_d, ceil_q, ceil_d, lim_q, lim_d;
	logic [7:0] flags_q, flags_d, events, stat_view;
	brc_pkg::ctrl_t ctrl_q, ctrl_d;
	logic pg_oe_q, pg_oe_d, pin_ok;

	// Every pin crosses three flops; a level counts once the last two agree.
	assign raw = {pg_i, output_level_select_i, bypass_request_n_i, enable_i, sda_i, scl_i};
	for (genvar i = 0; i < brc_pkg::NUM_PINS; i++) begin : g_sync
		always_comb begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
		end
	end

	// Synchroniser and filtered pin registers.
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_q <= brc_pkg::PIN_RST;
			s2_q <= brc_pkg::PIN_RST;
			s3_q <= brc_pkg::PIN_RST;
			filt_q <= brc_pkg::PIN_RST;
			prev_q <= brc_pkg::PIN_RST;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			prev_q <= filt_q;
		end
	end

	// Bus events are taken from the filtered lines so glitches never clock the shifter.
	assign scl_f = filt_q[brc_pkg::PIN_SCL];
	assign sda_f = filt_q[brc_pkg::PIN_SDA];
	assign en_f = filt_q[brc_pkg::PIN_EN];
	assign byp_n_f = filt_q[brc_pkg::PIN_BYP_N];
	assign lvl_f = filt_q[brc_pkg::PIN_LVL];
	assign pg_f = filt_q[brc_pkg::PIN_PG];
	assign scl_rise = scl_f & ~prev_q[brc_pkg::PIN_SCL];
	assign scl_fall = ~scl_f & prev_q[brc_pkg::PIN_SCL];
	assign start_det = scl_f & prev_q[brc_pkg::PIN_SCL] & prev_q[brc_pkg::PIN_SDA] & ~sda_f;
	assign stop_det = scl_f & prev_q[brc_pkg::PIN_SCL] & ~prev_q[brc_pkg::PIN_SDA] & sda_f;

	// Read view: live levels plus the latched event flags.
	always_comb begin
		stat_view = flags_q;
		stat_view[brc_pkg::ST_HOT] = status_i.hot_die_flag;
		stat_view[brc_pkg::ST_PULSE] = status_i.pulse_mode_flag;
		stat_view[brc_pkg::ST_OP_MODE] = status_i.operation_mode_flag;
		stat_view[brc_pkg::ST_POWER_GOOD] = status_i.power_good_flag;
		case (ptr_q)
			brc_pkg::REG_CFG: rd_data = cfg_q;
			brc_pkg::REG_FLOOR: rd_data = floor_q;
			brc_pkg::REG_CEIL: rd_data = ceil_q;
			brc_pkg::REG_LIMIT: rd_data = lim_q;
			brc_pkg::REG_STAT: rd_data = stat_view;
			default: rd_data = brc_pkg::ZERO_BYTE;
		endcase
	end

	// Serial target: bits are sampled on clock rise, the data line changes on clock fall.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		oe_d = oe_q;
		wr_en = 1'b0;
		load = 1'b0;
		if (start_det) begin
			state_d = ST_ADDR;
			cnt_d = '0;
			oe_d = 1'b0;
		end else if (stop_det) begin
			state_d = ST_IDLE;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			case (state_q)
				ST_ADDR, ST_PTR, ST_WR: begin
					sh_d = {sh_q[6:0], sda_f};
					cnt_d = 3'(cnt_q + 3'h1);
					if (cnt_q == brc_pkg::BIT_LAST) begin
						if (state_q == ST_ADDR) begin
							rw_d = sda_f;
							state_d = (sh_q[6:0] == brc_pkg::DEV_ADDR) ? ST_ACK_ADDR : ST_IDLE; // R15
						end else if (state_q == ST_PTR) begin
							ptr_d = sh_d;
							state_d = ST_ACK_PTR;
						end else begin
							wr_en = 1'b1;
							ptr_d = 8'(ptr_q + 8'h01);
							state_d = ST_ACK_WR;
						end
					end
				end
				ST_ACK_ADDR: begin
					if (rw_q) begin
						load = 1'b1;
					end else begin
						state_d = ST_PTR;
					end
				end
				ST_ACK_PTR, ST_ACK_WR: state_d = ST_WR;
				ST_RD: begin
					tx_d = {tx_q[6:0], 1'b0};
					cnt_d = 3'(cnt_q + 3'h1);
					if (cnt_q == brc_pkg::BIT_LAST) begin
						state_d = ST_RD_ACK;
					end
				end
				ST_RD_ACK: begin
					if (!sda_f) begin
						load = 1'b1;
					end else begin
						state_d = ST_IDLE;
					end
				end
				default: ;
			endcase
			if (load) begin
				tx_d = rd_data;
				ptr_d = 8'(ptr_q + 8'h01);
				cnt_d = '0;
				state_d = ST_RD;
			end
		end else if (scl_fall) begin
			case (state_q)
				ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WR: oe_d = 1'b1;
				ST_RD: oe_d = ~tx_q[7];
				default: oe_d = 1'b0;
			endcase
		end
	end
	assign rd_stat = load && (ptr_q == brc_pkg::REG_STAT);

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			sh_q <= '0;
			tx_q <= '0;
			ptr_q <= '0;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
		end
	end

	// Register bank; a low enable pin holds every field at its reset value.
	always_comb begin
		events = '0;
		events[brc_pkg::ST_THERM] = status_i.thermal_shutdown_event;
		events[brc_pkg::ST_BYP_LIM] = status_i.bypass_current_limit_event;
		events[brc_pkg::ST_BST_LIM] = status_i.boost_current_limit_event;
		events[brc_pkg::ST_FAULT] = status_i.fault_event;
		cfg_d = cfg_q;
		floor_d = floor_q;
		ceil_d = ceil_q;
		lim_d = lim_q;
		// A new event in the readout cycle survives the clear.
		flags_d = (flags_q & ~(rd_stat ? brc_pkg::STICKY_MASK : brc_pkg::ZERO_BYTE)) | events; // R14
		if (!en_f) begin
			cfg_d = brc_pkg::CFG_RST; // R17
			floor_d = brc_pkg::FLOOR_RST; // R11
			ceil_d = brc_pkg::CEIL_RST; // R12
			lim_d = brc_pkg::LIMIT_RST; // R13
			flags_d = brc_pkg::ZERO_BYTE;
		end else if (wr_en) begin
			case (ptr_q)
				brc_pkg::REG_CFG: cfg_d = sh_d;
				brc_pkg::REG_FLOOR: floor_d = sh_d; // R10
				brc_pkg::REG_CEIL: ceil_d = sh_d;
				brc_pkg::REG_LIMIT: lim_d = sh_d;
				default: ; // R16
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_q <= brc_pkg::CFG_RST;
			floor_q <= brc_pkg::FLOOR_RST;
			ceil_q <= brc_pkg::CEIL_RST;
			lim_q <= brc_pkg::LIMIT_RST;
			flags_q <= brc_pkg::ZERO_BYTE;
		end else begin
			cfg_q <= cfg_d;
			floor_q <= floor_d;
			ceil_q <= ceil_d;
			lim_q <= lim_d;
			flags_q <= flags_d;
		end
	end

	// Control outputs; the power-good pin used as input can also force shutdown.
	assign pin_ok = cfg_q[brc_pkg::CFG_PG_BIT] | pg_f; // R6
	always_comb begin
		ctrl_d = '0;
		if (!en_f) begin
			ctrl_d.run_mode = brc_pkg::RUN_OFF;
		end else if (!pin_ok) begin
			ctrl_d.run_mode = brc_pkg::RUN_SHUTDOWN;
		end else begin
			case (cfg_q[brc_pkg::CFG_OVR_MSB:brc_pkg::CFG_OVR_LSB])
				brc_pkg::OVR_HW: ctrl_d.run_mode = byp_n_f ? brc_pkg::RUN_AUTO : brc_pkg::RUN_BYPASS; // R1
				brc_pkg::OVR_AUTO: ctrl_d.run_mode = brc_pkg::RUN_AUTO; // R2
				brc_pkg::OVR_BYPASS: ctrl_d.run_mode = brc_pkg::RUN_BYPASS; // R3
				default: ctrl_d.run_mode = brc_pkg::RUN_SHUTDOWN; // R4
			endcase
		end
		// The forbidden code 00 falls back to automatic PWM entry.
		case (cfg_q[brc_pkg::CFG_PM_MSB:brc_pkg::CFG_PM_LSB])
			brc_pkg::PM_FORCED: ctrl_d.forced_pwm = 1'b1; // R8
			brc_pkg::PM_BY_PIN: ctrl_d.forced_pwm = lvl_f; // R9
			default: ctrl_d.forced_pwm = 1'b0; // R8
		endcase
		ctrl_d.spread_spectrum_enable = cfg_q[brc_pkg::CFG_SS_BIT]; // R7
		ctrl_d.id_detect_enable = cfg_q[brc_pkg::CFG_ID_BIT]; // R5
		ctrl_d.power_good_pin_role = cfg_q[brc_pkg::CFG_PG_BIT]; // R6
		ctrl_d.target_code = lvl_f ? ceil_q[brc_pkg::CODE_MSB:0] : floor_q[brc_pkg::CODE_MSB:0];
		ctrl_d.current_limit_code = lim_q[brc_pkg::LIM_CODE_MSB:0]; // R13
		ctrl_d.current_limit_disable = lim_q[brc_pkg::LIM_OFF_BIT];
		ctrl_d.soft_start_limit = lim_q[brc_pkg::LIM_SS_BIT];
		pg_oe_d = cfg_q[brc_pkg::CFG_PG_BIT] & ~status_i.power_good_flag; // R6
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q <= '0;
			pg_oe_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			pg_oe_q <= pg_oe_d;
		end
	end

	// Both open-drain pins only ever pull low.
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_q;
	assign pg_o = 1'b0;
	assign pg_oe_o = pg_oe_q;
	assign ctrl_o = ctrl_q;

	logic [1:0] ovr_sel;
	logic [1:0] pm_sel;

	// Field views keep the checks short and free of bare bit positions.
	assign ovr_sel = cfg_q[brc_pkg::CFG_OVR_MSB:brc_pkg::CFG_OVR_LSB];
	assign pm_sel = cfg_q[brc_pkg::CFG_PM_MSB:brc_pkg::CFG_PM_LSB];

	// Checks on mode selection, flags and register reset.
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	property p_hw_follow;
		en_f && pin_ok && ovr_sel == brc_pkg::OVR_HW && !byp_n_f
			|=> ctrl_o.run_mode == brc_pkg::RUN_BYPASS;
	endproperty
	a_hw_follow: assert property (p_hw_follow) else $error("pin bypass not followed"); // R1
	property p_auto;
		en_f && pin_ok && ovr_sel == brc_pkg::OVR_AUTO |=> ctrl_o.run_mode == brc_pkg::RUN_AUTO;
	endproperty
	a_auto: assert property (p_auto) else $error("auto override lost"); // R2
	property p_bypass;
		en_f && pin_ok && ovr_sel == brc_pkg::OVR_BYPASS
			|=> ctrl_o.run_mode == brc_pkg::RUN_BYPASS;
	endproperty
	a_bypass: assert property (p_bypass) else $error("forced bypass lost"); // R3
	property p_shut;
		en_f && ovr_sel == brc_pkg::OVR_SHUT |=> ctrl_o.run_mode == brc_pkg::RUN_SHUTDOWN;
	endproperty
	a_shut: assert property (p_shut) else $error("shutdown override lost"); // R4
	property p_pin_role;
		!cfg_q[brc_pkg::CFG_PG_BIT] |=> !pg_oe_o;
	endproperty
	a_pin_role: assert property (p_pin_role) else $error("pg pin driven as input"); // R6
	property p_pm_pin;
		pm_sel == brc_pkg::PM_BY_PIN |=> ctrl_o.forced_pwm == $past(lvl_f);
	endproperty
	a_pm_pin: assert property (p_pm_pin) else $error("pulse mode ignores level pin"); // R9
	property p_pm_auto;
		pm_sel != brc_pkg::PM_FORCED && pm_sel != brc_pkg::PM_BY_PIN |=> !ctrl_o.forced_pwm;
	endproperty
	a_pm_auto: assert property (p_pm_auto) else $error("auto PWM forced"); // R8
	property p_sticky;
		en_f && status_i.fault_event |=> flags_q[brc_pkg::ST_FAULT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("fault event lost"); // R14
	property p_en_reset;
		!en_f [*2] |-> cfg_q == brc_pkg::CFG_RST && floor_q == brc_pkg::FLOOR_RST
			&& ceil_q == brc_pkg::CEIL_RST && lim_q == brc_pkg::LIMIT_RST;
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("fields not reset by enable"); // R17
	property p_no_ack;
		state_q == ST_ADDR && scl_rise && cnt_q == brc_pkg::BIT_LAST
			&& sh_q[6:0] != brc_pkg::DEV_ADDR |=> state_q == ST_IDLE;
	endproperty
	a_no_ack: assert property (p_no_ack) else $error("foreign address accepted"); // R15
	c_write: cover property (wr_en && ptr_q == brc_pkg::REG_CFG);
	c_read_stat: cover property (rd_stat);
	c_read_burst: cover property (state_q == ST_RD_ACK && scl_rise && !sda_f);
endmodule // boost_regulator_control_registers
